// ---- timer8_pwm_pkg.sv ----
// Constants, enumerations and state layout for the 8-bit PWM timer block.
// Assumes an AXI4-Lite master with 8-bit byte addresses and 32-bit data.
package timer8_pwm_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] CTRL_OFFSET    = 8'h00;
  localparam logic [7:0] COMPARE_OFFSET = 8'h04;
  localparam logic [7:0] COUNT_OFFSET   = 8'h08;
  localparam logic [7:0] STATUS_OFFSET  = 8'h0C;
  localparam logic [7:0] ACTIVE_OFFSET  = 8'h10;

  localparam int WGM_LSB   = 0;
  localparam int COM_LSB   = 2;
  localparam int CS_LSB    = 4;
  localparam int ASYNC_BIT = 7;
  localparam int DDR_BIT   = 8;
  localparam int PORT_BIT  = 9;
  localparam int PSR_BIT   = 10;
  localparam int OVF_BIT   = 0;
  localparam int OCF_BIT   = 1;
  localparam int WAVE_BIT  = 2;
  localparam int DIR_BIT   = 3;

  localparam logic [7:0] COUNT_MAX    = 8'hFF;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [7:0] COUNT_STEP   = 8'h01;

  localparam logic [9:0] MASK_DIV1    = 10'h000;
  localparam logic [9:0] MASK_DIV8    = 10'h007;
  localparam logic [9:0] MASK_DIV32   = 10'h01F;
  localparam logic [9:0] MASK_DIV64   = 10'h03F;
  localparam logic [9:0] MASK_DIV128  = 10'h07F;
  localparam logic [9:0] MASK_DIV256  = 10'h0FF;
  localparam logic [9:0] MASK_DIV1024 = 10'h3FF;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {WAVE_NORMAL, WAVE_PHASE, WAVE_CTC, WAVE_FAST} waveform_select_e;
  typedef enum logic [1:0] {COM_NONE, COM_TOGGLE, COM_CLEAR, COM_SET} compare_output_mode_e;
  typedef enum logic [2:0] {CS_STOP, CS_DIV1, CS_DIV8, CS_DIV32, CS_DIV64, CS_DIV128, CS_DIV256,
                            CS_DIV1024} clock_select_e;

  typedef struct packed {
    logic                 port_level;
    logic                 ddr;
    logic                 async_sel;
    clock_select_e        cs;
    compare_output_mode_e com;
    waveform_select_e     wgm;
  } ctrl_s;

  typedef struct packed {
    ctrl_s       ctrl;
    logic [7:0]  compare_buf;
    logic [7:0]  compare_act;
    logic [7:0]  count;
    logic        count_down;
    logic        wave;
    logic        ovf;
    logic        ocf;
    logic [9:0]  presc;
    logic        tosc_prev;
    logic        pin_out;
    logic        pin_oe;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        aw_got;
    logic [7:0]  aw_addr;
    logic        w_got;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
  } timer_state_s;

  localparam timer_state_s STATE_RESET = '{
    ctrl: '{port_level: 1'b0, ddr: 1'b0, async_sel: 1'b0, cs: CS_STOP, com: COM_NONE, wgm: WAVE_NORMAL},
    compare_buf: 8'h00, compare_act: 8'h00, count: 8'h00, count_down: 1'b0, wave: 1'b0,
    ovf: 1'b0, ocf: 1'b0, presc: 10'h000, tosc_prev: 1'b0, pin_out: 1'b0, pin_oe: 1'b0,
    awready: 1'b1, wready: 1'b1, bvalid: 1'b0, bresp: 2'h0, arready: 1'b1, rvalid: 1'b0,
    rdata: 32'h0000_0000, rresp: 2'h0, aw_got: 1'b0, aw_addr: 8'h00, w_got: 1'b0,
    wdata: 32'h0000_0000, wstrb: 4'h0};

endpackage

// ---- timer8_pwm.sv ----
// 8-bit timer with fast and phase-correct PWM waveform generation behind an AXI4-Lite slave.
// Assumes a single 125 MHz sys_clk; tosc_in is a slow oscillator level already synchronous to it.
//
// Behaviour
// - Fast PWM sets the overflow flag whenever the count reaches maximum.
// - Fast PWM output mode 2 gives non-inverted PWM, mode 3 inverted PWM.
// - Fast PWM sets or clears wave on match, opposite level when wrapping max to bottom.
// - Fast PWM period is 256 ticks; tick is clock divided by 1,8,32,64,128,256,1024.
// - Fast PWM compare at bottom gives a one-tick spike every 256 ticks.
// - Fast PWM compare at maximum holds output constant, level set by polarity.
// - Fast PWM output mode 1 toggles wave on every compare match.
// - Compare value is double buffered in fast PWM, unlike the clear-on-match mode.
// - Waveform select 1 is phase-correct PWM, counting up to max then down.
// - Phase-correct non-inverting clears on up-count match, sets on down-count match.
// - Phase-correct resolution is 8 bits; count stays at max one tick, then descends.
// - Phase-correct sets the overflow flag whenever the count reaches bottom.
// - Phase-correct period is 510 ticks of the prescaled clock.
// - Phase-correct compare bottom gives constant low, maximum constant high, non-inverted.
// - Leaving a maximum compare value, wave at maximum takes the up-count match result.
// - A missed up-count match is made up at maximum to keep symmetry.
// - Wave reaches the pin only while the pin direction is output.
// - Tick is a clock enable; async mode uses the timer oscillator instead.
// - Waveform select 3 is fast PWM, counting to max then bottom next tick.
// - Maximum count is 0xFF, bottom 0x00.
// - Output mode 0 leaves wave unchanged on compare matches in every mode.
`timescale 1ns/1ps

module timer8_pwm
  import timer8_pwm_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        tosc_in,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             wave_pin_out,
  output logic             wave_pin_oe,
  output logic             overflow_flag,
  output logic             compare_match_flag
);

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release through two flip-flops; assertion stays asynchronous.
  logic [1:0] rst_sync_ff;
  logic       rst_n;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      rst_sync_ff <= 2'h0;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end

  assign rst_n = rst_sync_ff[1];

  ////////////////////////////////////////////////////////////////////////////////
  timer_state_s st_ff;
  timer_state_s nxt_st;

  logic       wr_fire;
  logic       rd_fire;
  logic       wr_ctrl;
  logic       wr_compare;
  logic       wr_count;
  logic       wr_status;
  logic       wr_mapped;
  logic       src_en;
  logic       tick;
  logic       at_max;
  logic       at_bot;
  logic       match;
  logic       pwm_mode;
  logic [9:0] presc_mask;

  assign wr_fire    = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
  assign rd_fire    = s_axi_arvalid && st_ff.arready;
  assign wr_ctrl    = wr_fire && (st_ff.aw_addr == CTRL_OFFSET);
  assign wr_compare = wr_fire && (st_ff.aw_addr == COMPARE_OFFSET) && st_ff.wstrb[0];
  assign wr_count   = wr_fire && (st_ff.aw_addr == COUNT_OFFSET) && st_ff.wstrb[0];
  assign wr_status  = wr_fire && (st_ff.aw_addr == STATUS_OFFSET) && st_ff.wstrb[0];
  assign wr_mapped  = (st_ff.aw_addr == CTRL_OFFSET) || (st_ff.aw_addr == COMPARE_OFFSET)
                   || (st_ff.aw_addr == COUNT_OFFSET) || (st_ff.aw_addr == STATUS_OFFSET)
                   || (st_ff.aw_addr == ACTIVE_OFFSET);

  // The oscillator is slow against sys_clk, so one rising edge gives one enable pulse.
  assign src_en = st_ff.ctrl.async_sel ? (tosc_in && !st_ff.tosc_prev) : 1'b1;

  always_comb
  begin
    unique case (st_ff.ctrl.cs)
      CS_STOP:    presc_mask = MASK_DIV1;
      CS_DIV1:    presc_mask = MASK_DIV1;
      CS_DIV8:    presc_mask = MASK_DIV8;
      CS_DIV32:   presc_mask = MASK_DIV32;
      CS_DIV64:   presc_mask = MASK_DIV64;
      CS_DIV128:  presc_mask = MASK_DIV128;
      CS_DIV256:  presc_mask = MASK_DIV256;
      CS_DIV1024: presc_mask = MASK_DIV1024;
    endcase
  end

  assign tick = src_en && (st_ff.ctrl.cs != CS_STOP) && ((st_ff.presc & presc_mask) == presc_mask);

  assign at_max   = (st_ff.count == COUNT_MAX);
  assign at_bot   = (st_ff.count == COUNT_BOTTOM);
  assign match    = (st_ff.count == st_ff.compare_act);
  assign pwm_mode = (st_ff.ctrl.wgm == WAVE_FAST) || (st_ff.ctrl.wgm == WAVE_PHASE);

  ////////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.tosc_prev = tosc_in;

    // Write channels are taken independently; the write itself waits for both.
    if (s_axi_awvalid && st_ff.awready)
    begin
      nxt_st.aw_got  = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_ff.wready)
    begin
      nxt_st.w_got = 1'b1;
      nxt_st.wdata = s_axi_wdata;
      nxt_st.wstrb = s_axi_wstrb;
    end
    if (st_ff.bvalid && s_axi_bready)
      nxt_st.bvalid = 1'b0;
    if (wr_fire)
    begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got  = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp  = wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end

    // Flags clear first so that a hardware set in the same cycle wins.
    if (wr_status && st_ff.wdata[OVF_BIT])
      nxt_st.ovf = 1'b0;
    if (wr_status && st_ff.wdata[OCF_BIT])
      nxt_st.ocf = 1'b0;

    // Prescaler.
    if (wr_ctrl && st_ff.wstrb[1] && st_ff.wdata[PSR_BIT])
      nxt_st.presc = 10'h000;
    else if (src_en)
      nxt_st.presc = st_ff.presc + 10'h001;

    // Outside the PWM modes the compare value takes effect at once.
    if (!pwm_mode)
      nxt_st.compare_act = st_ff.compare_buf;

    if (tick)
    begin
      if (match)
        nxt_st.ocf = 1'b1;
      unique case (st_ff.ctrl.wgm)
        WAVE_FAST:
        begin
          nxt_st.count = at_max ? COUNT_BOTTOM : st_ff.count + COUNT_STEP;
          if (nxt_st.count == COUNT_MAX)
            nxt_st.ovf = 1'b1;
          if (at_max)
            nxt_st.compare_act = st_ff.compare_buf;
          if (match)
          begin
            unique case (st_ff.ctrl.com)
              COM_NONE:   nxt_st.wave = st_ff.wave;
              COM_TOGGLE: nxt_st.wave = !st_ff.wave;
              COM_CLEAR:  nxt_st.wave = 1'b0;
              COM_SET:    nxt_st.wave = 1'b1;
            endcase
          end
          // The wrap action comes last, so a compare at maximum holds the level and at bottom leaves a spike.
          if (at_max && (st_ff.ctrl.com == COM_CLEAR))
            nxt_st.wave = 1'b1;
          if (at_max && (st_ff.ctrl.com == COM_SET))
            nxt_st.wave = 1'b0;
        end
        WAVE_PHASE:
        begin
          if (!st_ff.count_down)
          begin
            if (at_max)
            begin
              nxt_st.count      = COUNT_MAX - COUNT_STEP;
              nxt_st.count_down = 1'b1;
            end
            else
              nxt_st.count = st_ff.count + COUNT_STEP;
          end
          else
          begin
            if (at_bot)
            begin
              nxt_st.count      = COUNT_BOTTOM + COUNT_STEP;
              nxt_st.count_down = 1'b0;
            end
            else
              nxt_st.count = st_ff.count - COUNT_STEP;
          end
          if (nxt_st.count == COUNT_BOTTOM)
            nxt_st.ovf = 1'b1;
          if (at_max)
            nxt_st.compare_act = st_ff.compare_buf;
          if (st_ff.ctrl.com == COM_CLEAR || st_ff.ctrl.com == COM_SET)
          begin
            if (match)
            begin
              if (!st_ff.count_down)
                nxt_st.wave = (st_ff.ctrl.com == COM_SET);
              else
                nxt_st.wave = (st_ff.ctrl.com == COM_CLEAR);
            end
            // At maximum the level is forced to the up-count result for symmetry around bottom.
            if (at_max)
              nxt_st.wave = (st_ff.ctrl.com == COM_SET);
            if (nxt_st.compare_act == COUNT_BOTTOM)
              nxt_st.wave = (st_ff.ctrl.com == COM_SET);
            else if (nxt_st.compare_act == COUNT_MAX)
              nxt_st.wave = (st_ff.ctrl.com == COM_CLEAR);
          end
        end
        WAVE_CTC:
        begin
          nxt_st.count = match ? COUNT_BOTTOM : st_ff.count + COUNT_STEP;
          if (at_max && !match)
            nxt_st.ovf = 1'b1;
          if (match && st_ff.ctrl.com == COM_TOGGLE)
            nxt_st.wave = !st_ff.wave;
        end
        WAVE_NORMAL:
        begin
          nxt_st.count = st_ff.count + COUNT_STEP;
          if (at_max)
            nxt_st.ovf = 1'b1;
          if (match && st_ff.ctrl.com == COM_TOGGLE)
            nxt_st.wave = !st_ff.wave;
        end
      endcase
    end

    // Register writes take effect after the timer step so that software wins over the count.
    if (wr_ctrl && st_ff.wstrb[0])
    begin
      nxt_st.ctrl.wgm       = waveform_select_e'(st_ff.wdata[WGM_LSB +: 2]);
      nxt_st.ctrl.com       = compare_output_mode_e'(st_ff.wdata[COM_LSB +: 2]);
      nxt_st.ctrl.cs        = clock_select_e'(st_ff.wdata[CS_LSB +: 3]);
      nxt_st.ctrl.async_sel = st_ff.wdata[ASYNC_BIT];
    end
    if (wr_ctrl && st_ff.wstrb[1])
    begin
      nxt_st.ctrl.ddr        = st_ff.wdata[DDR_BIT];
      nxt_st.ctrl.port_level = st_ff.wdata[PORT_BIT];
    end
    if (wr_compare)
      nxt_st.compare_buf = st_ff.wdata[7:0];
    if (wr_count)
    begin
      nxt_st.count      = st_ff.wdata[7:0];
      nxt_st.count_down = 1'b0;
    end

    // Pin override; wave_pin_out carries the wave whenever an output mode is set, and only wave_pin_oe follows the direction.
    nxt_st.pin_oe  = nxt_st.ctrl.ddr;
    nxt_st.pin_out = (nxt_st.ctrl.com != COM_NONE) ? nxt_st.wave : nxt_st.ctrl.port_level;

    nxt_st.awready = !nxt_st.aw_got && !nxt_st.bvalid;
    nxt_st.wready  = !nxt_st.w_got && !nxt_st.bvalid;

    // Read channel: answer one cycle after the address is taken.
    if (st_ff.rvalid && s_axi_rready)
    begin
      nxt_st.rvalid  = 1'b0;
      nxt_st.arready = 1'b1;
    end
    if (rd_fire)
    begin
      nxt_st.arready = 1'b0;
      nxt_st.rvalid  = 1'b1;
      nxt_st.rresp   = RESP_OKAY;
      nxt_st.rdata   = 32'h0000_0000;
      unique case (s_axi_araddr)
        CTRL_OFFSET:
        begin
          nxt_st.rdata[WGM_LSB +: 2] = st_ff.ctrl.wgm;
          nxt_st.rdata[COM_LSB +: 2] = st_ff.ctrl.com;
          nxt_st.rdata[CS_LSB +: 3]  = st_ff.ctrl.cs;
          nxt_st.rdata[ASYNC_BIT]    = st_ff.ctrl.async_sel;
          nxt_st.rdata[DDR_BIT]      = st_ff.ctrl.ddr;
          nxt_st.rdata[PORT_BIT]     = st_ff.ctrl.port_level;
        end
        COMPARE_OFFSET: nxt_st.rdata[7:0] = st_ff.compare_buf;
        COUNT_OFFSET:   nxt_st.rdata[7:0] = st_ff.count;
        STATUS_OFFSET:
        begin
          nxt_st.rdata[OVF_BIT]  = st_ff.ovf;
          nxt_st.rdata[OCF_BIT]  = st_ff.ocf;
          nxt_st.rdata[WAVE_BIT] = st_ff.wave;
          nxt_st.rdata[DIR_BIT]  = st_ff.count_down;
        end
        ACTIVE_OFFSET:  nxt_st.rdata[7:0] = st_ff.compare_act;
        default:        nxt_st.rresp = RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      st_ff <= STATE_RESET;
    else
      st_ff <= nxt_st;
  end

  ////////////////////////////////////////////////////////////////////////////////
  assign s_axi_awready      = st_ff.awready;
  assign s_axi_wready       = st_ff.wready;
  assign s_axi_bvalid       = st_ff.bvalid;
  assign s_axi_bresp        = st_ff.bresp;
  assign s_axi_arready      = st_ff.arready;
  assign s_axi_rvalid       = st_ff.rvalid;
  assign s_axi_rdata        = st_ff.rdata;
  assign s_axi_rresp        = st_ff.rresp;
  assign wave_pin_out       = st_ff.pin_out;
  assign wave_pin_oe        = st_ff.pin_oe;
  assign overflow_flag      = st_ff.ovf;
  assign compare_match_flag = st_ff.ocf;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks; a tick that coincides with a software write is excluded where the write may win.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  fast_ovf_set_a: assert property (
    tick && !wr_fire && st_ff.ctrl.wgm == WAVE_FAST && st_ff.count == COUNT_MAX - COUNT_STEP |=> st_ff.ovf)
    else $error("Overflow flag missing when fast count reached maximum.");

  fast_wrap_level_a: assert property (
    tick && !wr_fire && st_ff.ctrl.wgm == WAVE_FAST && at_max && st_ff.ctrl.com inside {COM_CLEAR, COM_SET}
    |=> st_ff.count == COUNT_BOTTOM && st_ff.wave == ($past(st_ff.ctrl.com) == COM_CLEAR))
    else $error("Fast wrap did not restore the wave level.");

  fast_toggle_a: assert property (
    tick && !wr_fire && st_ff.ctrl.wgm == WAVE_FAST && match && st_ff.ctrl.com == COM_TOGGLE
    |=> st_ff.wave != $past(st_ff.wave))
    else $error("Toggle mode did not toggle on match.");

  no_action_a: assert property (
    st_ff.ctrl.com == COM_NONE && !wr_fire |=> st_ff.wave == $past(st_ff.wave))
    else $error("Wave changed with output mode zero.");

  phase_turn_a: assert property (
    tick && !wr_fire && st_ff.ctrl.wgm == WAVE_PHASE && !st_ff.count_down && at_max
    |=> st_ff.count_down && st_ff.count == COUNT_MAX - COUNT_STEP)
    else $error("Phase count did not reverse after one tick at maximum.");

  phase_ovf_set_a: assert property (
    tick && !wr_fire && st_ff.ctrl.wgm == WAVE_PHASE && st_ff.count_down && st_ff.count == COUNT_STEP
    |=> st_ff.ovf ##1 (st_ff.ovf || ($past(wr_status) && $past(st_ff.wdata[OVF_BIT]))))
    else $error("Overflow flag missing at phase bottom.");

  match_flag_set_a: assert property (
    tick && pwm_mode && match |=> st_ff.ocf)
    else $error("Compare match flag not set after a match.");

  compare_hold_a: assert property (
    pwm_mode && !(tick && at_max) |=> st_ff.compare_act == $past(st_ff.compare_act))
    else $error("Active compare changed away from maximum.");

  phase_extreme_a: assert property (
    tick && !wr_fire && st_ff.ctrl.wgm == WAVE_PHASE && st_ff.ctrl.com == COM_CLEAR
    && st_ff.compare_act == COUNT_MAX && st_ff.compare_buf == COUNT_MAX |=> st_ff.wave)
    else $error("Phase compare at maximum not held high.");

  pin_enable_a: assert property (
    wave_pin_oe == st_ff.ctrl.ddr && (st_ff.ctrl.com == COM_NONE || wave_pin_out == st_ff.wave))
    else $error("Pin does not follow direction and wave.");

endmodule // timer8_pwm

// ---- pin_load.sv ----
// External load on the timer's wave pin, seen as a resolved pad level.
// Assumes the pin driver splits into a level and an output enable.
`timescale 1ns/1ps
module pin_load
(
  input  wire logic pin_out,
  input  wire logic pin_oe,
  output logic      pad_level
);
  // A pull-down holds the pad low whenever the pin is not driven, so a released pin never reads as a high.
  assign pad_level = pin_oe ? pin_out : 1'b0;
endmodule // pin_load

// ---- test_timer8_pwm.sv ----
// Self-checking bench for the 8-bit PWM timer, driven over AXI4-Lite.
// Assumes timer8_pwm_pkg, timer8_pwm and pin_load are compiled before it.
`timescale 1ns/1ps
module test_timer8_pwm;
  import timer8_pwm_pkg::*;
  logic        sys_clk, rst_b, awvalid, wvalid, bready, arvalid, rready;
  logic        tosc_in = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, pin_out, pin_oe, ovf, ocf, pad_level;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0]  bresp, rresp;
  logic [2:0]  tosc_cnt = 3'h0;
  int          num_errors, check_count, i;
  int          cyc = 0;
  // Columns: waveform select, output mode, compare value, window, high cycles expected.
  int          tbl [12][5] = '{'{3, 2, 'h40, 256, 65}, '{3, 3, 'h40, 256, 191}, '{3, 2, 0, 256, 1},
                               '{3, 2, 'hFF, 256, 256}, '{3, 3, 'hFF, 256, 0}, '{3, 1, 0, 512, 256},
                               '{1, 2, 'h40, 510, 128}, '{1, 3, 'h40, 510, 382}, '{1, 2, 0, 510, 0},
                               '{1, 2, 'hFF, 510, 510}, '{1, 3, 'hFF, 510, 0}, '{3, 0, 'h40, 256, 256}};

  timer8_pwm u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .tosc_in(tosc_in), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .wave_pin_out(pin_out), .wave_pin_oe(pin_oe), .overflow_flag(ovf), .compare_match_flag(ocf));
  pin_load u_load (.pin_out(pin_out), .pin_oe(pin_oe), .pad_level(pad_level));

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // The oscillator rises once every eight system cycles, giving an exact period to check against.
  always @(posedge sys_clk)
  begin
    tosc_cnt <= tosc_cnt + 3'h1;
    tosc_in  <= tosc_cnt[2];
    cyc      <= cyc + 1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      $display("mismatch %s expected %h seen %h", name, exp, got);
      num_errors++;
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic hang(input string name);
    $display("mismatch %s expected handshake seen timeout", name);
    num_errors++;
    complete_run();
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    int n;
    @(posedge sys_clk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
    end
    if (n == 50) hang("write");
    bready <= 1'b0;
    chk("bresp", 32'(er), 32'(bresp));
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
    int n;
    @(posedge sys_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge sys_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
    end
    if (n == 50) hang("read");
    rready <= 1'b0;
    v = rdata;
    chk("rresp", 32'(er), 32'(rresp));
  endtask

  task automatic measure(input int n, input int exp);
    int c;
    c = 0;
    repeat (n)
    begin
      @(posedge sys_clk);
      if (pad_level === 1'b1) c++;
    end
    chk("high cycles", exp, c);
  endtask

  // Gap between two overflow flag rises, measured with a clear in between.
  task automatic ovf_gap(input int exp);
    int t0, n, k;
    t0 = 0;
    for (k = 0; k < 2; k++)
    begin
      axi_write(STATUS_OFFSET, 32'h0000_0001, RESP_OKAY);
      for (n = 0; n < 10000 && ovf !== 1'b1; n++) @(posedge sys_clk);
      if (n == 10000) hang("overflow");
      if (k == 0) t0 = cyc;
    end
    chk("overflow gap", exp, cyc - t0);
    $display("test period %0d done", exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {rst_b, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, num_errors, check_count} = '0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk("pin enable", 32'h0, 32'(pin_oe));
    axi_read(CTRL_OFFSET, d, RESP_OKAY);
    chk("ctrl reset", 32'h0, d);
    axi_read(STATUS_OFFSET, d, RESP_OKAY);
    chk("status reset", 32'h0, d);
    axi_read(8'h14, d, RESP_SLVERR);
    chk("unmapped data", 32'h0, d);
    axi_write(8'h14, 32'h0000_00FF, RESP_SLVERR);
    $display("test registers done");
    // Pin drive on, port level high, prescale by one; long settle lets the buffer load.
    for (i = 0; i < 12; i++)
    begin
      axi_write(COMPARE_OFFSET, tbl[i][2], RESP_OKAY);
      axi_write(CTRL_OFFSET, tbl[i][0] | (tbl[i][1] << 2) | 32'h310, RESP_OKAY);
      repeat (1100) @(posedge sys_clk);
      measure(tbl[i][3], tbl[i][4]);
      $display("test waveform %0d done", i);
    end
    axi_write(CTRL_OFFSET, 32'h0000_0303, RESP_OKAY);
    axi_write(COMPARE_OFFSET, 32'h0000_0080, RESP_OKAY);
    axi_read(ACTIVE_OFFSET, d, RESP_OKAY);
    chk("active held", 32'h40, d);
    axi_write(CTRL_OFFSET, 32'h0000_031B, RESP_OKAY);
    axi_write(STATUS_OFFSET, 32'h0000_0002, RESP_OKAY);
    repeat (600) @(posedge sys_clk);
    axi_read(ACTIVE_OFFSET, d, RESP_OKAY);
    chk("active loaded", 32'h80, d);
    measure(256, 129);
    axi_read(STATUS_OFFSET, d, RESP_OKAY);
    chk("match flag", 32'h1, (d >> 1) & 32'h1);
    chk("match flag pin", 32'h1, 32'(ocf));
    $display("test buffer done");
    axi_write(CTRL_OFFSET, 32'h0000_0323, RESP_OKAY);
    ovf_gap(2048);
    axi_write(CTRL_OFFSET, 32'h0000_0733, RESP_OKAY);
    ovf_gap(8192);
    axi_write(CTRL_OFFSET, 32'h0000_0311, RESP_OKAY);
    ovf_gap(510);
    axi_write(CTRL_OFFSET, 32'h0000_0393, RESP_OKAY);
    ovf_gap(2048);
    axi_write(CTRL_OFFSET, 32'h0000_001B, RESP_OKAY);
    repeat (3) @(posedge sys_clk);
    chk("pin released", 32'h0, 32'({pin_oe, pad_level}));
    $display("test direction done");
    complete_run();
  end
endmodule // test_timer8_pwm
